// File: src/fiu_host.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Query capabilities with 0041h before any transfer.
// - Start with 0101h carrying exactly header_length_field header bytes.
// - Host zeroes its next-block address before the first block.
// - Host sends the image in consecutive blocks within block size.
// - Host may skip blocks made only of the erased byte.
// - Host may read back the block it sent most recently.
// - Host sends 0107h after all data; device validates and reports.
// - On failure, terminate with 0107h or abort 0102h before retry.
// - Readback sends header only and requests image size minus header.
// - Host sends 0107h when readback finishes or fails; with the abort bit set, a failed readback sends 0102h instead.
module fiu_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [15:0] cmd_code,
  output logic [31:0] cmd_addr,
  output logic [15:0] cmd_len,
  output logic [31:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_status,
  input wire logic [31:0] rsp_data
);
  fiu_pkg::fiu_state_e st, next_st;
  logic phase, next_phase;
  logic next_cmd_valid;
  logic [15:0] next_cmd_code, next_cmd_len;
  logic [31:0] next_cmd_addr, next_cmd_data;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [7:0] ctrl, next_ctrl;
  logic [31:0] img_len, next_img_len;
  logic [31:0] data_word, next_data_word;
  logic data_full, next_data_full;
  logic [31:0] rd_word, next_rd_word;
  logic rd_full, next_rd_full;
  logic fail, next_fail;
  logic caps_ok, next_caps_ok;
  logic [15:0] hdr_len, next_hdr_len;
  logic [7:0] erase_b, next_erase_b;
  logic [7:0] blk_max, next_blk_max;
  logic [31:0] addr, next_addr;
  logic [31:0] last_addr, next_last_addr;
  logic [15:0] hdr_idx, next_hdr_idx;
  logic [7:0] last_sts, next_last_sts;
  logic [7:0] bank, next_bank;
  logic [31:0] rem;
  logic [15:0] blen, hrem, hlen;
  logic issue, rsp_ok, rsp_bad, wr_acc, rd_acc, rb, term_st;

  // ****************************************************
  // Sequencer and register file
  // ****************************************************
  always_comb begin
    next_st = st;
    next_phase = phase;
    next_cmd_valid = cmd_valid;
    next_cmd_code = cmd_code;
    next_cmd_addr = cmd_addr;
    next_cmd_len = cmd_len;
    next_cmd_data = cmd_data;
    next_ctrl = ctrl;
    next_img_len = img_len;
    next_data_word = data_word;
    next_data_full = data_full;
    next_rd_word = rd_word;
    next_rd_full = rd_full;
    next_fail = fail;
    next_caps_ok = caps_ok;
    next_hdr_len = hdr_len;
    next_erase_b = erase_b;
    next_blk_max = blk_max;
    next_addr = addr;
    next_last_addr = last_addr;
    next_hdr_idx = hdr_idx;
    next_last_sts = last_sts;
    next_bank = bank;
    rb = ctrl[fiu_pkg::CTL_RB];
    term_st = 1'b0;
    rem = img_len - addr;
    blen = fiu_pkg::WORD_BYTES;
    if (rem < {16'h0000, blen}) begin
      blen = rem[15:0];
    end
    if ({8'h00, blk_max} < blen) begin
      blen = {8'h00, blk_max};
    end
    hrem = hdr_len - hdr_idx;
    hlen = (hrem < fiu_pkg::WORD_BYTES) ? hrem : fiu_pkg::WORD_BYTES;
    issue = !phase && !cmd_valid;
    rsp_ok = rsp_valid && phase && !rsp_status[fiu_pkg::STS_FAIL_BIT];
    rsp_bad = rsp_valid && phase && rsp_status[fiu_pkg::STS_FAIL_BIT];
    wr_acc = psel && penable && pready && pwrite;
    rd_acc = psel && penable && pready && !pwrite;
    // Zero wait states: setup decodes, access completes
    next_pready = psel && !penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && !penable) begin
      case (paddr)
        fiu_pkg::REG_CTRL: next_prdata = {24'h0, ctrl};
        fiu_pkg::REG_LEN: next_prdata = img_len;
        fiu_pkg::REG_DATA: next_prdata = rd_word;
        fiu_pkg::REG_STAT: next_prdata = {8'h0, last_sts, 4'h0, st,
          3'h0, caps_ok, fail, rd_full, data_full, st != fiu_pkg::S_IDLE};
        fiu_pkg::REG_CAPS: next_prdata = {blk_max, erase_b, hdr_len};
        fiu_pkg::REG_BANK: next_prdata = {24'h0, bank};
        default: begin
          next_prdata = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      endcase
    end
    // Clear before the sequencer so a same-cycle fill wins
    if (rd_acc && paddr == fiu_pkg::REG_DATA) begin
      next_rd_full = 1'b0;
    end
    if (cmd_valid && cmd_ready) begin
      next_cmd_valid = 1'b0;
      next_phase = 1'b1;
    end
    if (rsp_valid && phase) begin
      next_phase = 1'b0;
      next_last_sts = rsp_status;
    end
    case (st)
      fiu_pkg::S_IDLE: begin
        if (wr_acc && paddr == fiu_pkg::REG_CTRL) begin
          if (pwdata[fiu_pkg::CTL_GO]) begin
            next_fail = 1'b0;
            next_caps_ok = 1'b0;
            next_addr = 32'h0000_0000;
            next_hdr_idx = 16'h0000;
            next_st = fiu_pkg::S_CAPS;
          end else if (pwdata[fiu_pkg::CTL_INFO]) begin
            next_st = fiu_pkg::S_INFO;
          end
        end
      end
      fiu_pkg::S_CAPS: begin
        if (issue) begin
          next_cmd_valid = 1'b1;
          next_cmd_code = fiu_pkg::CMD_CAPS;
          next_cmd_addr = 32'h0000_0000;
          next_cmd_len = 16'h0000;
        end
        if (rsp_bad || (rsp_ok && rsp_data[31:24] == 8'h00)) begin
          next_fail = 1'b1;
          next_st = fiu_pkg::S_IDLE;
        end else if (rsp_ok) begin
          next_hdr_len = rsp_data[fiu_pkg::CAP_HDR_LSB +: 16];
          next_erase_b = rsp_data[fiu_pkg::CAP_ERASE_LSB +: 8];
          next_blk_max = rsp_data[fiu_pkg::CAP_BLK_LSB +: 8];
          next_caps_ok = 1'b1;
          next_st = fiu_pkg::S_HDR;
        end
      end
      fiu_pkg::S_HDR: begin
        if (issue && data_full) begin
          next_cmd_valid = 1'b1;
          next_cmd_code = fiu_pkg::CMD_START;
          next_cmd_addr = {16'h0000, hdr_idx};
          next_cmd_len = hlen;
          next_cmd_data = data_word;
          next_data_full = 1'b0;
        end
        if (rsp_bad) begin
          term_st = 1'b1;
        end else if (rsp_ok) begin
          next_hdr_idx = hdr_idx + hlen;
          if (hdr_idx + hlen >= hdr_len) begin
            // Readback asks for img_len bytes beyond the header
            next_st = (img_len == 32'h0) ? fiu_pkg::S_CMPL
                                         : fiu_pkg::S_WDAT;
          end
        end
      end
      fiu_pkg::S_WDAT: begin
        if (rb) begin
          if (!rd_full) begin
            next_st = fiu_pkg::S_BLK;
          end
        end else if (data_full) begin
          if (ctrl[fiu_pkg::CTL_SKIP] && blen == fiu_pkg::WORD_BYTES
              && data_word == {4{erase_b}}) begin
            next_data_full = 1'b0;
            next_addr = addr + 32'h0000_0004;
            if (rem <= 32'h0000_0004) begin
              next_st = fiu_pkg::S_CMPL;
            end
          end else begin
            next_st = fiu_pkg::S_BLK;
          end
        end
      end
      fiu_pkg::S_BLK: begin
        if (issue) begin
          next_cmd_valid = 1'b1;
          if (rb) begin
            next_cmd_code = ctrl[fiu_pkg::CTL_EPL] ? fiu_pkg::CMD_RD_EPL
                                                   : fiu_pkg::CMD_RD_LPL;
          end else begin
            next_cmd_code = ctrl[fiu_pkg::CTL_EPL] ? fiu_pkg::CMD_WR_EPL
                                                   : fiu_pkg::CMD_WR_LPL;
            next_cmd_data = data_word;
            next_data_full = 1'b0;
          end
          next_cmd_addr = addr;
          next_cmd_len = blen;
          next_last_addr = addr;
        end
        if (rsp_bad) begin
          term_st = 1'b1;
        end else if (rsp_ok) begin
          if (rb) begin
            next_rd_word = rsp_data;
            next_rd_full = 1'b1;
          end
          next_addr = addr + {16'h0000, cmd_len};
          if (ctrl[fiu_pkg::CTL_VRFY] && !rb) begin
            next_st = fiu_pkg::S_VRFY;
          end else if (rem <= {16'h0000, cmd_len}) begin
            next_st = fiu_pkg::S_CMPL;
          end else begin
            next_st = fiu_pkg::S_WDAT;
          end
        end
      end
      fiu_pkg::S_VRFY: begin
        // Data field is left alone: it is the word to compare
        if (issue) begin
          next_cmd_valid = 1'b1;
          next_cmd_code = ctrl[fiu_pkg::CTL_EPL] ? fiu_pkg::CMD_RD_EPL
                                                 : fiu_pkg::CMD_RD_LPL;
          next_cmd_addr = last_addr;
        end
        if (rsp_bad || (rsp_ok && rsp_data != cmd_data)) begin
          term_st = 1'b1;
        end else if (rsp_ok) begin
          next_st = (addr >= img_len) ? fiu_pkg::S_CMPL
                                      : fiu_pkg::S_WDAT;
        end
      end
      fiu_pkg::S_CMPL, fiu_pkg::S_ABRT: begin
        if (issue) begin
          next_cmd_valid = 1'b1;
          next_cmd_code = (st == fiu_pkg::S_ABRT) ? fiu_pkg::CMD_ABORT
                                                  : fiu_pkg::CMD_DONE;
          next_cmd_len = 16'h0000;
        end
        if (rsp_valid && phase) begin
          next_fail = fail || rsp_bad;
          next_st = fiu_pkg::S_INFO;
        end
      end
      fiu_pkg::S_INFO: begin
        if (issue) begin
          next_cmd_valid = 1'b1;
          next_cmd_code = fiu_pkg::CMD_INFO;
          next_cmd_addr = fiu_pkg::BANK_STS_OFS;
          next_cmd_len = 16'h0001;
        end
        if (rsp_ok) begin
          next_bank = rsp_data[7:0];
        end
        if (rsp_valid && phase) begin
          next_fail = fail || rsp_bad;
          next_st = fiu_pkg::S_IDLE;
        end
      end
      default: next_st = fiu_pkg::S_IDLE;
    endcase
    if (term_st) begin
      // Failed transfer is always closed before a retry
      next_fail = 1'b1;
      next_st = ctrl[fiu_pkg::CTL_ABORT] ? fiu_pkg::S_ABRT
                                         : fiu_pkg::S_CMPL;
    end
    if (wr_acc) begin
      case (paddr)
        fiu_pkg::REG_CTRL: begin
          if (st == fiu_pkg::S_IDLE) begin
            next_ctrl = {pwdata[7:1], 1'b0};
          end
        end
        fiu_pkg::REG_LEN: begin
          if (st == fiu_pkg::S_IDLE) begin
            next_img_len = pwdata;
          end
        end
        fiu_pkg::REG_DATA: begin
          // A write is dropped only if the slot is still full after this cycle's consume
          if (!next_data_full) begin
            next_data_word = pwdata;
            next_data_full = 1'b1;
          end
        end
        default: next_ctrl = next_ctrl;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= fiu_pkg::S_IDLE;
      phase <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 16'h0000;
      cmd_addr <= 32'h0000_0000;
      cmd_len <= 16'h0000;
      cmd_data <= 32'h0000_0000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl <= fiu_pkg::CTRL_RST;
      img_len <= 32'h0000_0000;
      data_word <= 32'h0000_0000;
      data_full <= 1'b0;
      rd_word <= 32'h0000_0000;
      rd_full <= 1'b0;
      fail <= 1'b0;
      caps_ok <= 1'b0;
      hdr_len <= 16'h0000;
      erase_b <= 8'h00;
      blk_max <= 8'h00;
      addr <= 32'h0000_0000;
      last_addr <= 32'h0000_0000;
      hdr_idx <= 16'h0000;
      last_sts <= 8'h00;
      bank <= 8'h00;
    end else begin
      st <= next_st;
      phase <= next_phase;
      cmd_valid <= next_cmd_valid;
      cmd_code <= next_cmd_code;
      cmd_addr <= next_cmd_addr;
      cmd_len <= next_cmd_len;
      cmd_data <= next_cmd_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      ctrl <= next_ctrl;
      img_len <= next_img_len;
      data_word <= next_data_word;
      data_full <= next_data_full;
      rd_word <= next_rd_word;
      rd_full <= next_rd_full;
      fail <= next_fail;
      caps_ok <= next_caps_ok;
      hdr_len <= next_hdr_len;
      erase_b <= next_erase_b;
      blk_max <= next_blk_max;
      addr <= next_addr;
      last_addr <= next_last_addr;
      hdr_idx <= next_hdr_idx;
      last_sts <= next_last_sts;
      bank <= next_bank;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_caps_first;
    cmd_valid && cmd_code == fiu_pkg::CMD_START |-> caps_ok;
  endproperty
  a_caps_first: assert property (p_caps_first)
    else $error("start sent before capability query");
  property p_hdr_len;
    cmd_valid && cmd_code == fiu_pkg::CMD_START
      |-> cmd_addr[15:0] + cmd_len <= hdr_len && cmd_len != 16'h0;
  endproperty
  a_hdr_len: assert property (p_hdr_len)
    else $error("header bytes exceed header length");
  property p_addr_zero;
    $rose(st == fiu_pkg::S_CAPS) |-> addr == 32'h0 && hdr_idx == 16'h0;
  endproperty
  a_addr_zero: assert property (p_addr_zero)
    else $error("block address not zeroed at start");
  property p_blk_size;
    cmd_valid && (cmd_code == fiu_pkg::CMD_WR_LPL ||
      cmd_code == fiu_pkg::CMD_WR_EPL) |-> cmd_len != 16'h0 &&
      cmd_len <= {8'h00, blk_max} && cmd_addr + cmd_len <= img_len;
  endproperty
  a_blk_size: assert property (p_blk_size)
    else $error("write block size out of range");
  property p_skip;
    cmd_valid && cmd_code == fiu_pkg::CMD_WR_LPL && cmd_len == 16'h4
      && ctrl[fiu_pkg::CTL_SKIP] |-> cmd_data != {4{erase_b}};
  endproperty
  a_skip: assert property (p_skip)
    else $error("erased block was sent");
  property p_complete;
    st == fiu_pkg::S_BLK && next_st == fiu_pkg::S_CMPL
      |-> ##[1:3] cmd_valid && cmd_code == fiu_pkg::CMD_DONE;
  endproperty
  a_complete: assert property (p_complete)
    else $error("complete command not issued after last block");
  property p_term;
    rsp_bad && st != fiu_pkg::S_CAPS && st != fiu_pkg::S_INFO
      && st != fiu_pkg::S_CMPL && st != fiu_pkg::S_ABRT
      |-> ##[2:3] cmd_valid && (cmd_code == fiu_pkg::CMD_DONE ||
      cmd_code == fiu_pkg::CMD_ABORT);
  endproperty
  a_term: assert property (p_term)
    else $error("failed transfer not terminated");
  property p_rb_len;
    cmd_valid && rb && (cmd_code == fiu_pkg::CMD_RD_LPL ||
      cmd_code == fiu_pkg::CMD_RD_EPL)
      |-> cmd_addr + {16'h0000, cmd_len} <= img_len;
  endproperty
  a_rb_len: assert property (p_rb_len)
    else $error("readback request beyond image length");
  property p_hold;
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_code)
      && $stable(cmd_addr) && $stable(cmd_len);
  endproperty
  a_hold: assert property (p_hold)
    else $error("command changed while waiting for ready");
  c_download: cover property (st == fiu_pkg::S_BLK && !rb
    ##[1:100] cmd_valid && cmd_code == fiu_pkg::CMD_DONE);
  c_readback: cover property (rb && rd_full && st == fiu_pkg::S_WDAT);
  c_abort: cover property (cmd_valid && cmd_code == fiu_pkg::CMD_ABORT);
  c_skip: cover property (st == fiu_pkg::S_WDAT && $changed(addr));
endmodule
`default_nettype wire

// File: src/fiu_pkg.sv
package fiu_pkg;
  // Message command codes
  localparam logic [15:0] CMD_CAPS = 16'h0041;
  localparam logic [15:0] CMD_INFO = 16'h0100;
  localparam logic [15:0] CMD_START = 16'h0101;
  localparam logic [15:0] CMD_ABORT = 16'h0102;
  localparam logic [15:0] CMD_WR_LPL = 16'h0103;
  localparam logic [15:0] CMD_WR_EPL = 16'h0104;
  localparam logic [15:0] CMD_RD_LPL = 16'h0105;
  localparam logic [15:0] CMD_RD_EPL = 16'h0106;
  localparam logic [15:0] CMD_DONE = 16'h0107;
  // Device side image_bank_status_byte location
  localparam logic [31:0] BANK_STS_OFS = 32'h0000_0088;
  // Own APB register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_CAPS = 8'h10;
  localparam logic [7:0] REG_BANK = 8'h14;
  // Control register bit positions
  localparam int CTL_GO = 0;
  localparam int CTL_RB = 1;
  localparam int CTL_ABORT = 2;
  localparam int CTL_EPL = 3;
  localparam int CTL_INFO = 4;
  localparam int CTL_SKIP = 5;
  localparam int CTL_VRFY = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Capability reply field positions
  localparam int CAP_HDR_LSB = 0;
  localparam int CAP_ERASE_LSB = 16;
  localparam int CAP_BLK_LSB = 24;
  // Failure bit of command_status_byte in replies
  localparam int STS_FAIL_BIT = 6;
  localparam logic [15:0] WORD_BYTES = 16'h0004;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CAPS = 4'h1, S_HDR = 4'h3, S_WDAT = 4'h2,
    S_BLK = 4'h6, S_VRFY = 4'h7, S_CMPL = 4'h5, S_INFO = 4'h4,
    S_ABRT = 4'hc
  } fiu_state_e;
endpackage

// File: sim/fiu_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************
// Module side of the message command channel
// ************************************************
module fiu_dev_model #(
  parameter logic [15:0] HDR_LEN = 16'h0008,
  parameter logic [7:0] ERASED = 8'hff,
  parameter logic [7:0] BLK_MAX = 8'h04
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [15:0] cmd_code,
  input wire logic [31:0] cmd_addr,
  input wire logic [15:0] cmd_len,
  input wire logic [31:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_status,
  output logic [31:0] rsp_data
);
  logic [31:0] mem [8];
  logic [31:0] log_q [$];
  logic [7:0] bank;
  logic [15:0] code, len;
  logic [31:0] addr, data, img_len, top;
  logic pend, active, rb, failed, bad;
  int dly;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_status <= 8'h00;
      rsp_data <= 32'h0;
      pend <= 1'b0;
      active <= 1'b0;
      rb <= 1'b0;
      failed <= 1'b0;
      dly <= 0;
      bank <= 8'h03;
    end else begin
      rsp_valid <= 1'b0;
      // Reply lines wander between replies so stale data is never reused
      rsp_status <= ~rsp_status;
      rsp_data <= ~rsp_data;
      if (cmd_valid && cmd_ready) begin
        cmd_ready <= 1'b0;
        pend <= 1'b1;
        code <= cmd_code;
        addr <= cmd_addr;
        len <= cmd_len;
        data <= cmd_data;
        dly <= slow ? 6 : 0;
      end else if (pend && dly != 0) begin
        dly <= dly - 1;
      end else if (pend) begin
        pend <= 1'b0;
        bad = 1'b0;
        rsp_data <= 32'h0;
        log_q.push_back({code, (code == fiu_pkg::CMD_CAPS ||
          code == fiu_pkg::CMD_DONE || code == fiu_pkg::CMD_ABORT) ?
          16'h0 : addr[15:0]});
        case (code)
          fiu_pkg::CMD_CAPS: rsp_data <= {BLK_MAX, ERASED, HDR_LEN};
          fiu_pkg::CMD_INFO: begin
            bad = addr != fiu_pkg::BANK_STS_OFS;
            rsp_data <= {24'h0, bank};
          end
          fiu_pkg::CMD_START: begin
            bad = active;
            if (!active && addr == 32'h0) begin
              rb <= data[0];
            end
            if (!active && addr == 32'h4) begin
              active <= 1'b1;
              failed <= 1'b0;
              top <= 32'h0;
              img_len <= data;
              if (!rb) begin
                bank <= 8'h43;
                for (int i = 0; i < 8; i++) begin
                  mem[i] <= {4{ERASED}};
                end
              end
            end
          end
          fiu_pkg::CMD_WR_LPL, fiu_pkg::CMD_WR_EPL: begin
            bad = !active || rb || addr + 32'(len) > img_len;
            if (!bad) begin
              mem[addr[4:2]] <= data;
              top <= addr + 32'(len);
            end
            failed <= failed || bad;
          end
          fiu_pkg::CMD_RD_LPL, fiu_pkg::CMD_RD_EPL: begin
            // Block reads also serve the verify step of a download
            bad = !active || addr + 32'(len) > img_len;
            if (!bad) begin
              rsp_data <= mem[addr[4:2]];
            end
          end
          fiu_pkg::CMD_DONE: begin
            bad = !active || (!rb && (failed || top != img_len));
            active <= 1'b0;
            if (!bad && !rb) begin
              bank <= 8'h03;
            end
          end
          fiu_pkg::CMD_ABORT: active <= 1'b0;
          default: bad = 1'b1;
        endcase
        rsp_valid <= 1'b1;
        rsp_status <= bad ? 8'h40 : 8'h01;
      end else begin
        // Slow mode holds ready off so the host must keep its request
        cmd_ready <= !slow || cmd_valid;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/test_firmware_image_update_engine.sv
`timescale 1ns/1ns
`default_nettype none
module test_firmware_image_update_engine;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, rsp_status;
  logic [31:0] pwdata, prdata, cmd_addr, cmd_data, rsp_data, rd;
  logic cmd_valid, cmd_ready, rsp_valid, slow, err;
  logic [15:0] cmd_code, cmd_len;
  int bad_count = 0;
  int num_checks = 0;

  fiu_host fiu_host_inst (.clk(clk), .nrst(nrst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_data(rsp_data));
  fiu_dev_model fiu_dev_model_inst (.clk(clk), .nrst(nrst), .slow(slow),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_data(rsp_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk32(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_up(input string what);
    bad_count++;
    $display("wrong value %s expected done seen timeout", what);
    test_done();
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) give_up("pready");
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Status polling keeps every wait bounded
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, fiu_pkg::REG_STAT, 32'h0);
      n++;
      if (n > 300) give_up("status wait");
    end while (rd[b] !== v);
  endtask

  task automatic push(input logic [31:0] w);
    poll(1, 1'b0);
    apb(1'b1, fiu_pkg::REG_DATA, w);
  endtask

  task automatic pop(input logic [31:0] exp);
    poll(2, 1'b1);
    apb(1'b0, fiu_pkg::REG_DATA, 32'h0);
    chk32("readback word", exp, rd);
  endtask

  task automatic start(input logic [7:0] ctl, input logic [31:0] len,
                       input logic [31:0] h0, input logic [31:0] h1);
    fiu_dev_model_inst.log_q.delete();
    apb(1'b1, fiu_pkg::REG_LEN, len);
    apb(1'b1, fiu_pkg::REG_CTRL, {24'h0, ctl});
    push(h0);
    push(h1);
  endtask

  task automatic finish_chk(input string name, input logic fail,
                            input logic [7:0] bank,
                            input logic [31:0] exp_log []);
    int got;
    poll(0, 1'b0);
    chk32("fail flag", {31'h0, fail}, {31'h0, rd[3]});
    apb(1'b0, fiu_pkg::REG_BANK, 32'h0);
    chk32("bank status", {24'h0, bank}, rd);
    got = fiu_dev_model_inst.log_q.size();
    chk32("command count", 32'(exp_log.size()), 32'(got));
    for (int i = 0; i < exp_log.size() && i < got; i++) begin
      chk32("command", exp_log[i], fiu_dev_model_inst.log_q[i]);
    end
    $display("test %s ended", name);
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_regs();
    apb(1'b0, fiu_pkg::REG_CTRL, 32'h0);
    chk32("control reset", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk32("unmapped error", 32'h1, {31'h0, err});
    chk32("unmapped data", 32'h0, rd);
    $display("test regs ended");
  endtask

  task automatic t_info();
    fiu_dev_model_inst.log_q.delete();
    apb(1'b1, fiu_pkg::REG_CTRL, 32'h0000_0010);
    finish_chk("info", 1'b0, 8'h03, '{32'h0100_0088});
  endtask

  task automatic t_download();
    slow <= 1'b0;
    start(8'h21, 32'd12, 32'h0, 32'd12);
    push(32'h1234_5678);
    push(32'hffff_ffff);
    push(32'h9abc_def0);
    finish_chk("download", 1'b0, 8'h03, '{32'h0041_0000, 32'h0101_0000,
      32'h0101_0004, 32'h0103_0000, 32'h0103_0008, 32'h0107_0000,
      32'h0100_0088});
    apb(1'b0, fiu_pkg::REG_CAPS, 32'h0);
    chk32("capabilities", 32'h04ff_0008, rd);
  endtask

  task automatic t_readback();
    slow <= 1'b1;
    start(8'h0b, 32'd12, 32'h1, 32'd12);
    pop(32'h1234_5678);
    pop(32'hffff_ffff);
    pop(32'h9abc_def0);
    finish_chk("readback", 1'b0, 8'h03, '{32'h0041_0000, 32'h0101_0000,
      32'h0101_0004, 32'h0106_0000, 32'h0106_0004, 32'h0106_0008,
      32'h0107_0000, 32'h0100_0088});
  endtask

  task automatic t_abort();
    slow <= 1'b0;
    start(8'h4d, 32'd12, 32'h0, 32'd8);
    push(32'h0000_0011);
    push(32'h0000_0022);
    push(32'h0000_0033);
    finish_chk("abort", 1'b1, 8'h43, '{32'h0041_0000, 32'h0101_0000,
      32'h0101_0004, 32'h0104_0000, 32'h0106_0000, 32'h0104_0004,
      32'h0106_0004, 32'h0104_0008, 32'h0102_0000,
      32'h0100_0088});
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_info();
    t_download();
    t_readback();
    t_abort();
    test_done();
  end
endmodule
`default_nettype wire
